// ==== common/stab_count_if.sv ====
// Link between the standby sequencer and the stabilization counter
`default_nettype none
`include "standby_osc_consts.svh"
interface stab_count_if #(
  parameter int unsigned NStat = `STAB_NUM_STATUS
);
  logic             clear;
  logic             tickEn;
  logic [2:0]       limitIdx;
  logic             done;
  logic [NStat-1:0] status;

  modport ctrl (output clear, output tickEn, output limitIdx, input done, input status);
  modport cnt  (input clear, input tickEn, input limitIdx, output done, output status);
endinterface
`default_nettype wire

// ==== common/standby_osc_consts.svh ====
// Offsets, field positions, reset values and counts of the stabilization block
`ifndef STANDBY_OSC_CONSTS_SVH
`define STANDBY_OSC_CONSTS_SVH

// Register byte offsets
`define OFS_STAB_STATUS     4'h0
`define OFS_STAB_SELECT     4'h4
`define OFS_OSC_CTRL        4'h8

// Control register fields
`define CTRL_RING_STOP_BIT  0
`define CTRL_RING_ON_BIT    1
`define CTRL_CPU_HOLD_BIT   2
`define CTRL_STOP_BIT       3
`define CTRL_HALT_BIT       4
`define CTRL_XTAL_UP_BIT    5

// Stabilization status layout
`define STAB_NUM_STATUS     5
`define STAB_SHORTEST_EXP   11
`define STAB_CNT_WIDTH      16
`define STAB_SEL_WIDTH      3
`define STAB_SEL_RESET      3'h4

// CPU hold after STOP release when running from the ring oscillator
`define RING_HOLD_PERIODS   17
`define RING_HOLD_WIDTH     5

`endif

// ==== common/standby_osc_pkg.sv ====
// Types shared by the standby oscillator stabilization block
`default_nettype none
package standby_osc_pkg;

  // Standby sequence states
  typedef enum logic [2:0] {
    SeqRun,
    SeqHalt,
    SeqStop,
    SeqRingHold,
    SeqWaitStab
  } seq_state_e;

  typedef logic [2:0] sel_t;

endpackage
`default_nettype wire

// ==== hdl/stab_counter.sv ====
// Crystal stabilization counter with sticky threshold status bits
`default_nettype none
`include "standby_osc_consts.svh"
module stab_counter
  import standby_osc_pkg::*;
#(
  parameter int unsigned CntWidth = `STAB_CNT_WIDTH,
  parameter int unsigned NStat    = `STAB_NUM_STATUS
)(
  input  wire logic  clk_sys,
  input  wire logic  rst_n,
  stab_count_if.cnt  cif
);

  typedef struct packed {
    logic [CntWidth-1:0] count;
    logic [NStat-1:0]    status;
  } cnt_state_s;

  cnt_state_s st_q;
  cnt_state_s st_d;

  // Tick count at which status bit idx rises
  function automatic logic [CntWidth-1:0] threshold(input int unsigned idx);
    threshold = CntWidth'(1) << (`STAB_SHORTEST_EXP + idx);
  endfunction

  // Count stops once the selected bit is up, so later bits never rise
  always_comb
  begin
    logic [CntWidth-1:0] nextCount;
    nextCount = st_q.count + CntWidth'(1);
    st_d      = st_q;
    if (cif.clear)
    begin
      st_d.count  = '0;
      st_d.status = '0;
    end
    else if (cif.tickEn && !cif.done)
    begin
      st_d.count = nextCount;
      for (int unsigned i = 0; i < NStat; i++)
      begin
        // Shortest first, each bit sticky until the next restart
        if (i <= cif.limitIdx && nextCount == threshold(i))
          st_d.status[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign cif.status = st_q.status;
  assign cif.done   = st_q.status[cif.limitIdx];

endmodule // stab_counter
`default_nettype wire

// ==== hdl/standby_osc_stabilization.sv ====
// Standby sequencer, ring oscillator control and stabilization registers
// Operation
// - Running ring oscillator keeps running in STOP
// - Ring-clocked CPU held seventeen ring periods after STOP release
// - Status bits rise shortest first, stay set
// - Counter stops at the selected time
// - Wait counts only after oscillation has started
`default_nettype none
`include "standby_osc_consts.svh"
module standby_osc_stabilization
  import standby_osc_pkg::*;
#(
  parameter int unsigned NStat     = `STAB_NUM_STATUS,
  parameter int unsigned HoldTicks = `RING_HOLD_PERIODS
)(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output var  logic [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        stopEnter,
  input  wire logic        haltEnter,
  input  wire logic        wakeIrq,
  input  wire logic        wakeReset,
  input  wire logic        cpuOnRing,
  input  wire logic        xtalStarted,
  input  wire logic        xtalTick,
  input  wire logic        ringTick,
  output logic             xtalOscEn,
  output logic             ringOscEn,
  output logic             cpuHold,
  output logic             stopMode,
  output logic             haltMode
);

  typedef struct packed {
    seq_state_e                  seq;
    logic                        ack;
    logic [31:0]                 rdata;
    logic [`STAB_SEL_WIDTH-1:0]  select;
    logic                        ringStopReq;
    logic                        ringOn;
    logic                        countGate;
    logic [`RING_HOLD_WIDTH-1:0] holdCnt;
  } top_state_s;

  top_state_s st_q;
  top_state_s st_d;

  stab_count_if #(.NStat(NStat)) cif ();

  stab_counter #(
    .CntWidth (`STAB_CNT_WIDTH),
    .NStat    (NStat)
  ) u_counter (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .cif     (cif)
  );

  logic busReq;
  logic busWr;
  logic wake;

  // One wait state: data is fetched on the first edge, handed over on the second
  assign busReq          = avs_read | avs_write;
  assign busWr           = avs_write & st_q.ack;
  assign avs_waitrequest = busReq & ~st_q.ack;
  assign wake            = wakeIrq | wakeReset;

  // Read mux over the three registers, unmapped reads return zero
  function automatic logic [31:0] readMux(input logic [3:0] addr, input top_state_s s,
                                          input logic [NStat-1:0] stat);
    readMux = '0;
    unique case (addr)
      `OFS_STAB_STATUS: readMux[NStat-1:0] = stat;
      `OFS_STAB_SELECT: readMux[`STAB_SEL_WIDTH-1:0] = s.select;
      `OFS_OSC_CTRL:
      begin
        readMux[`CTRL_RING_STOP_BIT] = s.ringStopReq;
        readMux[`CTRL_RING_ON_BIT]   = s.ringOn;
        readMux[`CTRL_CPU_HOLD_BIT]  = (s.seq != SeqRun);
        readMux[`CTRL_STOP_BIT]      = (s.seq == SeqStop);
        readMux[`CTRL_HALT_BIT]      = (s.seq == SeqHalt);
        readMux[`CTRL_XTAL_UP_BIT]   = xtalStarted;
      end
      default: readMux = '0;
    endcase
  endfunction

  // Bus slave, standby sequence and ring oscillator control
  always_comb
  begin
    st_d         = st_q;
    cif.clear    = 1'b0;
    cif.limitIdx = st_q.select;

    // Bus handshake and register writes
    st_d.ack = busReq & ~st_q.ack;
    if (busReq && !st_q.ack)
      st_d.rdata = readMux(avs_address, st_q, cif.status);
    if (busWr && avs_byteenable[0])
    begin
      if (avs_address == `OFS_STAB_SELECT
          && avs_writedata[`STAB_SEL_WIDTH-1:0] < `STAB_SEL_WIDTH'(NStat))
        st_d.select = avs_writedata[`STAB_SEL_WIDTH-1:0];
      if (avs_address == `OFS_OSC_CTRL)
        st_d.ringStopReq = avs_writedata[`CTRL_RING_STOP_BIT];
    end

    // A CPU running from the ring oscillator keeps it alive
    if (st_q.seq != SeqStop)
      st_d.ringOn = ~st_q.ringStopReq | cpuOnRing;
    // In STOP the ring oscillator is left as it was on entry
    else
      st_d.ringOn = st_q.ringOn;

    // Counting ends with the selected threshold
    if (cif.done)
      st_d.countGate = 1'b0;

    unique case (st_q.seq)
      SeqRun:
      begin
        if (stopEnter)
          st_d.seq = SeqStop;
        else if (haltEnter)
          st_d.seq = SeqHalt;
      end
      SeqHalt:
      begin
        // Crystal never stopped, so no stabilization wait
        if (wake)
          st_d.seq = SeqRun;
      end
      SeqStop:
      begin
        if (wake)
        begin
          cif.clear      = 1'b1;
          st_d.countGate = 1'b1;
          st_d.holdCnt   = '0;
          st_d.seq       = cpuOnRing ? SeqRingHold : SeqWaitStab;
        end
      end
      SeqRingHold:
      begin
        // Crystal keeps counting in the background meanwhile
        if (ringTick)
        begin
          st_d.holdCnt = st_q.holdCnt + `RING_HOLD_WIDTH'(1);
          if (st_q.holdCnt == `RING_HOLD_WIDTH'(HoldTicks - 1))
            st_d.seq = SeqRun;
        end
      end
      SeqWaitStab:
      begin
        if (cif.done)
          st_d.seq = SeqRun;
      end
    endcase
  end

  // Ticks before the crystal is up are not part of the wait
  assign cif.tickEn = st_q.countGate & xtalStarted & xtalTick;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q             <= '0;
      st_q.seq         <= SeqRun;
      st_q.select      <= `STAB_SEL_RESET;
      st_q.ringOn      <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  // Outputs straight from state flops
  assign avs_readdata = st_q.rdata;
  assign xtalOscEn    = (st_q.seq != SeqStop);
  assign ringOscEn    = st_q.ringOn;
  assign cpuHold      = (st_q.seq != SeqRun);
  assign stopMode     = (st_q.seq == SeqStop);
  assign haltMode     = (st_q.seq == SeqHalt);

endmodule // standby_osc_stabilization
`default_nettype wire

// ==== verif/standby_osc_assertions.sv ====
// Port checks for the standby stabilization block
`default_nettype none
`include "standby_osc_consts.svh"
module standby_osc_chk #(
  parameter int unsigned HoldTicks = `RING_HOLD_PERIODS
)(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_waitrequest,
  input wire logic stopEnter,
  input wire logic wakeIrq,
  input wire logic cpuOnRing,
  input wire logic xtalStarted,
  input wire logic ringTick,
  input wire logic ringOscEn,
  input wire logic xtalOscEn,
  input wire logic cpuHold,
  input wire logic stopMode,
  input wire logic haltMode
);
  logic [7:0] ringCnt_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Ring periods seen while held; STOP restarts it
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      ringCnt_q <= 8'h00;
    else if (stopMode)
      ringCnt_q <= 8'h00;
    else if (ringTick && cpuHold)
      ringCnt_q <= ringCnt_q + 8'h01;
  chk_ring_kept: assert property (stopMode |-> $stable(ringOscEn))
    else $error("ring oscillator changed in STOP");
  chk_stop_entry: assert property (stopEnter && !cpuHold |=> stopMode)
    else $error("STOP not entered");
  chk_stop_held: assert property (stopMode |-> cpuHold && !xtalOscEn)
    else $error("STOP without hold or with crystal on");
  chk_ring_count: assert property (cpuOnRing && $fell(cpuHold) && !$past(haltMode)
    |-> ringCnt_q == 8'(HoldTicks)) else $error("ring hold length wrong");
  chk_wake_release: assert property (stopMode && wakeIrq |=> !stopMode && xtalOscEn)
    else $error("release did not restart crystal");
  chk_wait_starts: assert property ($fell(stopMode) |-> cpuHold)
    else $error("CPU freed at release");
  chk_wait_gated: assert property (cpuHold && !stopMode && !haltMode && !cpuOnRing
    && !xtalStarted |=> cpuHold) else $error("wait ended without oscillation");
  chk_bus_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait state wrong");
  cover property ($fell(cpuHold) && cpuOnRing);
  cover property ($fell(cpuHold) && !cpuOnRing);
  cover property (stopMode && wakeIrq);
endmodule // standby_osc_chk

bind standby_osc_stabilization standby_osc_chk #(.HoldTicks(HoldTicks)) chkU (
  .clk_sys, .rst_n, .avs_read, .avs_waitrequest, .stopEnter, .wakeIrq, .cpuOnRing,
  .xtalStarted, .ringTick, .ringOscEn, .xtalOscEn, .cpuHold, .stopMode, .haltMode
);
`default_nettype wire

// ==== verif/standby_osc_stabilization_tb.sv ====
// Self-checking bench for the standby stabilization block
`default_nettype none
module standby_osc_stabilization_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, rst_n, avs_read, avs_write, avs_waitrequest;
  logic        stopEnter, haltEnter, wakeIrq, wakeReset, cpuOnRing, xtalStarted;
  logic        xtalOscEn, ringOscEn, cpuHold, stopMode, haltMode;
  logic        ringTick = 1'b0;
  logic [1:0]  ringDiv = 2'h0;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdData;
  int          errCount, checkCount;

  standby_osc_stabilization dut_u (
    .clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_byteenable(4'h1),
    .avs_writedata, .avs_readdata, .avs_waitrequest, .stopEnter, .haltEnter,
    .wakeIrq, .wakeReset, .cpuOnRing, .xtalStarted, .xtalTick(1'b1), .ringTick,
    .xtalOscEn, .ringOscEn, .cpuHold, .stopMode, .haltMode
  );

  // Ring period every fourth clock, free running
  always @(posedge clk_sys)
  begin
    ringDiv <= ringDiv + 2'h1;
    ringTick <= ringDiv == 2'h0;
  end

  task automatic endOfTest();
    $display("checks %0d errors %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      errCount++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Holds the request until waitrequest is seen low, then one idle edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rdData = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdChk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp(rdData, exp);
  endtask

  task automatic regsTest();
    rdChk(4'h0, 32'h0);
    rdChk(4'h4, 32'h4);
    bus(1'b1, 4'h4, 32'h7);
    rdChk(4'h4, 32'h4);
    bus(1'b1, 4'h0, 32'h1f);
    rdChk(4'h0, 32'h0);
    rdChk(4'hc, 32'h0);
  endtask

  // Crystal held silent after release, so the wait must not run early
  task automatic xtalRun(input logic [2:0] sel, input logic byPin);
    logic [31:0] mask;
    time t0;
    mask = (32'h2 << sel) - 32'h1;
    cpuOnRing <= 1'b0;
    xtalStarted <= 1'b0;
    bus(1'b1, 4'h4, {29'h0, sel});
    stopEnter <= 1'b1;
    @(posedge clk_sys);
    stopEnter <= 1'b0;
    repeat (5) @(posedge clk_sys);
    wakeIrq <= !byPin;
    wakeReset <= byPin;
    @(posedge clk_sys);
    wakeIrq <= 1'b0;
    wakeReset <= 1'b0;
    repeat (100) @(posedge clk_sys);
    rdChk(4'h0, 32'h0);
    xtalStarted <= 1'b1;
    t0 = $time;
    while (cpuHold === 1'b1)
    begin
      bus(1'b0, 4'h0, 32'h0);
      cmp((rdData & (rdData + 32'h1)) | (rdData & ~mask), 32'h0);
    end
    cmp(32'(($time - t0) / 10 >= (2048 << sel)), 32'h1);
    rdChk(4'h0, mask);
    repeat (2100 << sel) @(posedge clk_sys);
    rdChk(4'h0, mask);
  endtask

  // HALT keeps the crystal running and frees the CPU one cycle after wake
  task automatic haltRun();
    haltEnter <= 1'b1;
    @(posedge clk_sys);
    haltEnter <= 1'b0;
    @(posedge clk_sys);
    cmp({30'h0, haltMode, xtalOscEn}, 32'h3);
    wakeIrq <= 1'b1;
    @(posedge clk_sys);
    wakeIrq <= 1'b0;
    @(posedge clk_sys);
    cmp({30'h0, haltMode, cpuHold}, 32'h0);
  endtask

  task automatic ringRun();
    int n;
    n = 0;
    bus(1'b1, 4'h4, 32'h4);
    cpuOnRing <= 1'b1;
    stopEnter <= 1'b1;
    @(posedge clk_sys);
    stopEnter <= 1'b0;
    repeat (5) @(posedge clk_sys);
    cmp({31'h0, ringOscEn}, 32'h1);
    cmp({30'h0, stopMode, xtalOscEn}, 32'h2);
    wakeIrq <= 1'b1;
    @(posedge clk_sys);
    wakeIrq <= 1'b0;
    #1;
    while (cpuHold === 1'b1)
    begin
      @(posedge clk_sys);
      n += ringTick;
      #1;
    end
    cmp(32'(n), 32'h11);
  endtask

  // Clock at 100 MHz
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Cuts a hang short well past the expected run
  initial
  begin
    #400000;
    errCount++;
    endOfTest();
  end

  // Reset for ten cycles, then the scenarios
  initial
  begin
    {rst_n, avs_read, avs_write, stopEnter, wakeIrq, wakeReset} = 6'h00;
    {cpuOnRing, xtalStarted, haltEnter, avs_address} = 7'h00;
    avs_writedata = 32'h0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    regsTest();
    xtalRun(3'h0, 1'b0);
    xtalRun(3'h1, 1'b1);
    haltRun();
    ringRun();
    endOfTest();
  end
endmodule // standby_osc_stabilization_tb
`default_nettype wire
